// ---- design/cmwt_pkg.sv ----
// package: register map, field layout and constants of the compare match waveform timer
package cmwt_pkg;

    // register byte offsets (one aligned word each)
    localparam logic [7:0] ADDR_TIMER_CONTROL  = 8'h00;
    localparam logic [7:0] ADDR_TIMER_MODE     = 8'h04;
    localparam logic [7:0] ADDR_PIN_OUTPUT     = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ENABLE     = 8'h0C;
    localparam logic [7:0] ADDR_STATUS         = 8'h10;
    localparam logic [7:0] ADDR_COUNT          = 8'h14;
    localparam logic [7:0] ADDR_COMPARE_A      = 8'h18;
    localparam logic [7:0] ADDR_COMPARE_B      = 8'h1C;
    localparam logic [7:0] ADDR_COUNT_START    = 8'h20;
    localparam logic [7:0] ADDR_SYNC_SELECT    = 8'h24;
    localparam logic [7:0] ADDR_MODULE_STOP    = 8'h28;

    // timer_control fields
    localparam int CLK_SEL_LSB   = 0;    // count_clock_select [2:0]
    localparam int CLR_SEL_LSB   = 5;    // counter_clear_select [7:5]
    // pin_output_control fields
    localparam int ACT_A_LSB     = 0;    // output_action_a [3:0]
    localparam int ACT_B_LSB     = 4;    // output_action_b [7:4]
    // status / enable bit positions
    localparam int BIT_A         = 0;
    localparam int BIT_B         = 1;

    // field encodings
    localparam logic [2:0] CLR_NONE      = 3'h0;   // free running
    localparam logic [2:0] CLR_MATCH_A   = 3'h1;
    localparam logic [2:0] CLR_MATCH_B   = 3'h2;
    localparam logic [3:0] MODE_NORMAL   = 4'h0;

    // reset values
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
    localparam logic        STOP_RESET   = 1'b1;       // module held stopped

    // axi response codes
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // output action decode of one 4-bit field
    typedef struct packed {
        logic enabled;     // pin driven at all
        logic init_level;  // level before any match
        logic [1:0] match; // 1: low, 2: high, 3: toggle
    } cmwt_action_t;

    // match event pair
    typedef struct packed {
        logic b;
        logic a;
    } cmwt_pair_t;

endpackage : cmwt_pkg

// ---- design/cmwt_timer.sv ----
// file: compare match waveform timer channel with an axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
module cmwt_timer #(
    parameter int PRESCALE_W = 12   // width of the count clock prescaler
) (
    // clock and reset
    input  wire  logic        CLK_SYS,
    input  wire  logic        ARST_N,
    // axi4-lite write address
    input  wire  logic [7:0]  S_AXI_AWADDR,
    input  wire  logic        S_AXI_AWVALID,
    output logic              S_AXI_AWREADY,
    // axi4-lite write data
    input  wire  logic [31:0] S_AXI_WDATA,
    input  wire  logic [3:0]  S_AXI_WSTRB,
    input  wire  logic        S_AXI_WVALID,
    output logic              S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0]        S_AXI_BRESP,
    output logic              S_AXI_BVALID,
    input  wire  logic        S_AXI_BREADY,
    // axi4-lite read address
    input  wire  logic [7:0]  S_AXI_ARADDR,
    input  wire  logic        S_AXI_ARVALID,
    output logic              S_AXI_ARREADY,
    // axi4-lite read data
    output logic [31:0]       S_AXI_RDATA,
    output logic [1:0]        S_AXI_RRESP,
    output logic              S_AXI_RVALID,
    input  wire  logic        S_AXI_RREADY,
    // waveform pins
    output logic              WAVEFORM_PIN_A,
    output logic              WAVEFORM_PIN_A_OE,
    output logic              WAVEFORM_PIN_B,
    output logic              WAVEFORM_PIN_B_OE,
    // interrupt requests
    output logic              MATCH_INTERRUPT_A,
    output logic              MATCH_INTERRUPT_B
);

    // decode one output action field
    function automatic cmwt_pkg::cmwt_action_t decode_action(input logic [3:0] f);
        cmwt_pkg::cmwt_action_t r;
        r.enabled    = (f[3] == 1'b0) && (f[1:0] != 2'b00);
        r.init_level = f[2];
        r.match      = f[1:0];
        return r;
    endfunction : decode_action

    // next pin level after a match
    function automatic logic pin_next(input cmwt_pkg::cmwt_action_t a, input logic cur);
        logic r;
        case (a.match)
            2'b01:   r = 1'b0;
            2'b10:   r = 1'b1;
            2'b11:   r = ~cur;
            default: r = cur;
        endcase
        return r;
    endfunction : pin_next

    // software registers
    logic [2:0]  clk_sel_q;        // count_clock_select
    logic [2:0]  clr_sel_q;        // counter_clear_select
    logic [3:0]  mode_q;           // operating_mode_field
    logic [3:0]  act_a_q;          // output_action_a
    logic [3:0]  act_b_q;          // output_action_b
    logic [1:0]  irq_en_q;         // match_irq_enable_b/a
    logic        start_q;          // count_start_bit
    logic        sync_q;           // synchronous_select (no partner channel here)
    logic        stop_q;           // module stop state
    logic [15:0] cmp_a_q;          // compare_value_a
    logic [15:0] cmp_b_q;          // compare_value_b
    logic [15:0] count_q;          // timer_count
    logic [1:0]  flag_q;           // match_flag_b/a
    logic [1:0]  flag_seen_q;      // flag was read as 1
    logic        pin_a_q;
    logic        pin_b_q;
    logic [PRESCALE_W-1:0] pre_q;  // free prescaler for count clock

    // bus handshake state
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // one write fires when both halves are held and no response is pending
    logic wr_fire;
    logic rd_fire;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    assign rd_fire = S_AXI_ARVALID && !rvalid_q;

    assign S_AXI_AWREADY = !aw_hold_q && !bvalid_q;
    assign S_AXI_WREADY  = !w_hold_q && !bvalid_q;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;

    // byte-lane merge of the held write data (low two lanes only used)
    logic [15:0] wmask;
    logic [15:0] wdat;
    assign wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wdat  = w_data_q[15:0];

    // write decode strobes
    logic wr_ok;
    logic wr_stat;
    logic wr_count;
    // writes while module-stopped touch only the stop register
    assign wr_ok    = wr_fire && (!stop_q || aw_addr_q == cmwt_pkg::ADDR_MODULE_STOP);
    assign wr_stat  = wr_ok && aw_addr_q == cmwt_pkg::ADDR_STATUS && w_strb_q[0];
    assign wr_count = wr_ok && aw_addr_q == cmwt_pkg::ADDR_COUNT;

    // count clock: select 0 counts every cycle, n counts every 4^n cycles;
    // a mask wider than the prescaler saturates at its full period
    logic                  tick;
    logic [PRESCALE_W-1:0] tick_mask;   // low prescaler bits that must all be set
    always_comb begin
        tick_mask = PRESCALE_W'((32'h1 << (2 * clk_sel_q)) - 32'h1);
        tick      = (pre_q & tick_mask) == tick_mask;
    end

    // compare matches and their decoded actions
    cmwt_pkg::cmwt_pair_t   match;
    cmwt_pkg::cmwt_action_t dec_a;
    cmwt_pkg::cmwt_action_t dec_b;
    logic                   run;
    assign run     = start_q && !stop_q;
    assign match.a = run && tick && (count_q == cmp_a_q);
    assign match.b = run && tick && (count_q == cmp_b_q);
    assign dec_a   = decode_action(act_a_q);
    assign dec_b   = decode_action(act_b_q);

    // prescaler runs freely while the unit is out of module stop
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            pre_q <= '0;
        end else if (stop_q) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRESCALE_W'(1);
        end
    end

    // write address and data capture, in either order
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= {S_AXI_AWADDR[7:2], 2'b00};
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            bvalid_q <= 1'b0;
            bresp_q  <= cmwt_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (aw_addr_q > cmwt_pkg::ADDR_MODULE_STOP) ? cmwt_pkg::RESP_SLVERR
                                                                  : cmwt_pkg::RESP_OKAY;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // configuration registers; software keeps irqs off while changing them
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            clk_sel_q <= '0;
            clr_sel_q <= cmwt_pkg::CLR_NONE;
            mode_q    <= cmwt_pkg::MODE_NORMAL;
            act_a_q   <= '0;
            act_b_q   <= '0;
            irq_en_q  <= '0;
            start_q   <= 1'b0;
            sync_q    <= 1'b0;
            stop_q    <= cmwt_pkg::STOP_RESET;
            cmp_a_q   <= cmwt_pkg::COMPARE_RESET;
            cmp_b_q   <= cmwt_pkg::COMPARE_RESET;
        end else if (wr_ok && w_strb_q[0]) begin
            case (aw_addr_q)
                cmwt_pkg::ADDR_TIMER_CONTROL: begin
                    clk_sel_q <= wdat[cmwt_pkg::CLK_SEL_LSB +: 3];
                    clr_sel_q <= wdat[cmwt_pkg::CLR_SEL_LSB +: 3];
                end
                cmwt_pkg::ADDR_TIMER_MODE:  mode_q   <= wdat[3:0];
                cmwt_pkg::ADDR_PIN_OUTPUT: begin
                    act_a_q <= wdat[cmwt_pkg::ACT_A_LSB +: 4];
                    act_b_q <= wdat[cmwt_pkg::ACT_B_LSB +: 4];
                end
                cmwt_pkg::ADDR_IRQ_ENABLE:  irq_en_q <= wdat[1:0];
                cmwt_pkg::ADDR_COUNT_START: start_q  <= wdat[0];
                cmwt_pkg::ADDR_SYNC_SELECT: sync_q   <= wdat[0];
                cmwt_pkg::ADDR_MODULE_STOP: stop_q   <= wdat[0];
                cmwt_pkg::ADDR_COMPARE_A:   cmp_a_q  <= (cmp_a_q & ~wmask) | (wdat & wmask);
                cmwt_pkg::ADDR_COMPARE_B:   cmp_b_q  <= (cmp_b_q & ~wmask) | (wdat & wmask);
                default: begin
                end
            endcase
        end else if (wr_ok && w_strb_q[1]) begin
            // upper byte only reaches the 16-bit compare values
            if (aw_addr_q == cmwt_pkg::ADDR_COMPARE_A) begin
                cmp_a_q <= (cmp_a_q & ~wmask) | (wdat & wmask);
            end else if (aw_addr_q == cmwt_pkg::ADDR_COMPARE_B) begin
                cmp_b_q <= (cmp_b_q & ~wmask) | (wdat & wmask);
            end
        end
    end

    // counter: direct write wins, else counts on tick while started and out of module stop
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            count_q <= cmwt_pkg::COUNT_RESET;
        end else if (wr_count) begin
            count_q <= (count_q & ~wmask) | (wdat & wmask);
        end else if (run && tick) begin
            // sync_q has no partner here, so no foreign clear reaches us
            if ((clr_sel_q == cmwt_pkg::CLR_MATCH_A && match.a) ||
                (clr_sel_q == cmwt_pkg::CLR_MATCH_B && match.b)) begin
                count_q <= cmwt_pkg::COUNT_RESET;
            end else begin
                count_q <= count_q + 16'h0001;                        // wraps
            end
        end
    end

    // match flags: set wins over clear; clear needs a prior read of 1
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            flag_q      <= '0;
            flag_seen_q <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (match[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (wr_stat && !wdat[i] && flag_seen_q[i]) begin
                    flag_q[i]      <= 1'b0;
                    flag_seen_q[i] <= 1'b0;
                end
                if (rd_fire && S_AXI_ARADDR[7:2] == cmwt_pkg::ADDR_STATUS[7:2] && flag_q[i]) begin
                    flag_seen_q[i] <= 1'b1;
                end
            end
        end
    end

    // waveform pins: initial level while not started, action on match in normal mode only
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
        end else if (!start_q) begin
            pin_a_q <= dec_a.init_level;
            pin_b_q <= dec_b.init_level;
        end else if (mode_q == cmwt_pkg::MODE_NORMAL) begin
            if (match.a) begin
                pin_a_q <= pin_next(dec_a, pin_a_q);
            end
            if (match.b) begin
                pin_b_q <= pin_next(dec_b, pin_b_q);
            end
        end
    end

    assign WAVEFORM_PIN_A    = pin_a_q;
    assign WAVEFORM_PIN_B    = pin_b_q;
    assign WAVEFORM_PIN_A_OE = dec_a.enabled && !stop_q;
    assign WAVEFORM_PIN_B_OE = dec_b.enabled && !stop_q;
    // level requests follow flag and enable
    assign MATCH_INTERRUPT_A = flag_q[cmwt_pkg::BIT_A] && irq_en_q[cmwt_pkg::BIT_A];
    assign MATCH_INTERRUPT_B = flag_q[cmwt_pkg::BIT_B] && irq_en_q[cmwt_pkg::BIT_B];

    // read data mux
    logic [31:0] rd_mux;
    logic        rd_bad;
    always_comb begin
        rd_mux = '0;
        rd_bad = 1'b0;
        case ({S_AXI_ARADDR[7:2], 2'b00})
            cmwt_pkg::ADDR_TIMER_CONTROL: rd_mux[7:0] = {clr_sel_q, 2'b00, clk_sel_q};
            cmwt_pkg::ADDR_TIMER_MODE:    rd_mux[3:0] = mode_q;
            cmwt_pkg::ADDR_PIN_OUTPUT:    rd_mux[7:0] = {act_b_q, act_a_q};
            cmwt_pkg::ADDR_IRQ_ENABLE:    rd_mux[1:0] = irq_en_q;
            cmwt_pkg::ADDR_STATUS:        rd_mux[1:0] = flag_q;
            cmwt_pkg::ADDR_COUNT:         rd_mux[15:0] = count_q;
            cmwt_pkg::ADDR_COMPARE_A:     rd_mux[15:0] = cmp_a_q;
            cmwt_pkg::ADDR_COMPARE_B:     rd_mux[15:0] = cmp_b_q;
            cmwt_pkg::ADDR_COUNT_START:   rd_mux[0] = start_q;
            cmwt_pkg::ADDR_SYNC_SELECT:   rd_mux[0] = sync_q;
            cmwt_pkg::ADDR_MODULE_STOP:   rd_mux[0] = stop_q;
            default:                      rd_bad = 1'b1;
        endcase
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= cmwt_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_bad ? cmwt_pkg::RESP_SLVERR : cmwt_pkg::RESP_OKAY;
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : cmwt_timer
`default_nettype wire

// ---- test/cmwt_timer_chk.sv ----
// checker: bus handshake and waveform assertions bound to the timer channel
`timescale 1ns/10ps
`default_nettype none
module cmwt_timer_chk (
    // clock and reset
    input wire logic        CLK_SYS,
    input wire logic        ARST_N,
    // bus handshakes
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    // pins and requests
    input wire logic        WAVEFORM_PIN_A,
    input wire logic        WAVEFORM_PIN_B,
    input wire logic        MATCH_INTERRUPT_A
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);

    logic [2:0] wr_age_q;   // cycles since the last write response, saturating
    logic       wr_recent;  // a register write landed lately
    // only a register write may pull a level back, so remember writes a while
    assign wr_recent = S_AXI_BVALID || (wr_age_q < 3'h5);

    // age counter restarts on every write response
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) wr_age_q <= 3'h7;
        else if (S_AXI_BVALID) wr_age_q <= 3'h0;
        else if (wr_age_q != 3'h7) wr_age_q <= wr_age_q + 3'h1;
    end

    chk_reset_quiet: assert property (disable iff (1'b0)
        !ARST_N |-> !S_AXI_BVALID && !S_AXI_RVALID && !MATCH_INTERRUPT_A)
        else $error("output active during reset");
    chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    chk_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
        else $error("read answer dropped");
    chk_read_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("second read taken");
    chk_write_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while answering");
    chk_read_slverr: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
        S_AXI_ARADDR[7:2] > cmwt_pkg::ADDR_MODULE_STOP[7:2] |=>
        S_AXI_RRESP == cmwt_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
    chk_irq_clear: assert property ($fell(MATCH_INTERRUPT_A) |-> ##[0:2] wr_recent)
        else $error("request dropped without a write");
    chk_pin_a_hold: assert property ($fell(WAVEFORM_PIN_A) |-> ##[0:2] wr_recent)
        else $error("pin a fell without a write");
    chk_pin_b_hold: assert property ($rose(WAVEFORM_PIN_B) |-> ##[0:2] wr_recent)
        else $error("pin b rose without a write");

    // main scenarios
    cov_irq_a: cover property ($rose(MATCH_INTERRUPT_A));
    cov_pin_b: cover property ($fell(WAVEFORM_PIN_B));
    cov_slverr: cover property (S_AXI_RVALID && S_AXI_RRESP == cmwt_pkg::RESP_SLVERR);
endmodule : cmwt_timer_chk

bind cmwt_timer cmwt_timer_chk u_cmwt_timer_chk (
    .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .WAVEFORM_PIN_A(WAVEFORM_PIN_A), .WAVEFORM_PIN_B(WAVEFORM_PIN_B),
    .MATCH_INTERRUPT_A(MATCH_INTERRUPT_A)
);
`default_nettype wire

// ---- test/cmwt_timer_tb.sv ----
// testbench: register-level scenarios for the compare match waveform timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module cmwt_timer_tb;
    logic        clk_sys;                             // system clock
    logic        arst_n;                              // async reset, low active
    logic [7:0]  awaddr, araddr;                      // bus addresses
    logic [31:0] wdata, rdata, q, q2;                 // bus data and results
    logic        awvalid, awready, wvalid, wready;    // write handshakes
    logic        bvalid, bready, arvalid, arready;    // response and read handshakes
    logic        rvalid, rready;                      // read data handshake
    logic [1:0]  bresp, rresp, resp;                  // response codes
    logic        pin_a, pin_a_oe, pin_b, pin_b_oe;    // waveform pins
    logic        irq_a, irq_b;                        // match requests
    int          errors, n_tests, n, rr_delay;        // counters, read stall
    // set-up order: stop off, irqs off, halt, zero count, clear mode, normal,
    // independent, actions 0010b/0101b, compare points
    logic [7:0]  cfg_a [10] = '{cmwt_pkg::ADDR_MODULE_STOP, cmwt_pkg::ADDR_IRQ_ENABLE,
        cmwt_pkg::ADDR_COUNT_START, cmwt_pkg::ADDR_COUNT, cmwt_pkg::ADDR_TIMER_CONTROL,
        cmwt_pkg::ADDR_TIMER_MODE, cmwt_pkg::ADDR_SYNC_SELECT, cmwt_pkg::ADDR_PIN_OUTPUT,
        cmwt_pkg::ADDR_COMPARE_A, cmwt_pkg::ADDR_COMPARE_B};
    logic [31:0] cfg_d [10] = '{0, 0, 0, 0, 0, 0, 0, 32'h52, 32'h40, 32'h20};

    cmwt_timer #(.PRESCALE_W(12)) u_cmwt_timer (
        .CLK_SYS(clk_sys), .ARST_N(arst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .WAVEFORM_PIN_A(pin_a), .WAVEFORM_PIN_A_OE(pin_a_oe), .WAVEFORM_PIN_B(pin_b),
        .WAVEFORM_PIN_B_OE(pin_b_oe), .MATCH_INTERRUPT_A(irq_a), .MATCH_INTERRUPT_B(irq_b)
    );

    // 100 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // one bus transfer; handshakes judged at the falling edge, where all is settled
    task automatic bus(input logic rd_op, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] qo);
        int   k;
        logic a_t;
        logic w_t;
        logic r_t;
        k = 0;
        r_t = 1'b0;
        qo = '0;
        @(posedge clk_sys);
        if (rd_op) begin
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= (rr_delay == 0);
        end else begin
            awaddr  <= a;
            awvalid <= 1'b1;
            wdata   <= d;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
        end
        while (!r_t && k < 100) begin
            @(negedge clk_sys);
            a_t = rd_op ? (arvalid && arready) : (awvalid && awready);
            w_t = wvalid && wready;
            r_t = rd_op ? (rvalid && rready) : (bvalid && bready);
            qo = rd_op ? rdata : 32'h0;
            resp = rd_op ? rresp : bresp;
            @(posedge clk_sys);
            if (a_t && rd_op) arvalid <= 1'b0;
            if (a_t && !rd_op) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (r_t) begin
                rready <= 1'b0;
                bready <= 1'b0;
            end else if (rd_op && k + 1 >= rr_delay) rready <= 1'b1;
            k++;
        end
        // a hung handshake ends the run
        if (!r_t) begin
            errors++;
            tally_and_finish();
        end
    endtask : bus

    // count falling edges until a pin reaches a level, bounded
    task automatic wait_pin(input logic sel_b, input logic lvl);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while ((sel_b ? pin_b : pin_a) !== lvl && n < 400);
        if (n >= 400) begin
            errors++;
            tally_and_finish();
        end
    endtask : wait_pin

    // main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        {errors, n_tests, rr_delay} = '0;
        arst_n = 1'b0;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        // a stopped module ignores writes
        bus(1'b1, cmwt_pkg::ADDR_MODULE_STOP, 32'h0, q);
        `CHK(q, 32'h1)
        bus(1'b0, cmwt_pkg::ADDR_COMPARE_A, 32'h40, q);
        bus(1'b1, cmwt_pkg::ADDR_COMPARE_A, 32'h0, q);
        `CHK(q, 32'h0000FFFF)
        $display("test reset_stop done");
        for (int i = 0; i < 10; i++) bus(1'b0, cfg_a[i], cfg_d[i], q);
        bus(1'b1, cmwt_pkg::ADDR_STATUS, 32'h0, q);
        `CHK(q, 32'h0)
        bus(1'b0, cmwt_pkg::ADDR_IRQ_ENABLE, 32'h3, q);
        `CHK({pin_a, pin_a_oe, pin_b, pin_b_oe}, 4'b0111)
        $display("test setup done");
        // b falls at 20h, a rises exactly 20h cycles later
        bus(1'b0, cmwt_pkg::ADDR_COUNT_START, 32'h1, q);
        wait_pin(1'b1, 1'b0);
        `CHK(n >= 28 && n <= 38, 1'b1)
        `CHK({pin_a, irq_a, irq_b}, 3'b001)
        wait_pin(1'b0, 1'b1);
        `CHK(n, 32)
        `CHK({irq_a, irq_b}, 2'b11)
        repeat (8) @(posedge clk_sys);
        bus(1'b0, cmwt_pkg::ADDR_COUNT_START, 32'h0, q);
        bus(1'b1, cmwt_pkg::ADDR_COUNT, 32'h0, q);
        `CHK(q > 32'h40 && q < 32'h80, 1'b1)
        repeat (10) @(posedge clk_sys);
        bus(1'b1, cmwt_pkg::ADDR_COUNT, 32'h0, q2);
        `CHK(q2, q)
        $display("test match_run done");
        // mask b, then clear flags only by read-then-zero
        bus(1'b0, cmwt_pkg::ADDR_IRQ_ENABLE, 32'h1, q);
        `CHK({irq_a, irq_b}, 2'b10)
        bus(1'b0, cmwt_pkg::ADDR_STATUS, 32'h0, q);
        rr_delay = 3;
        bus(1'b1, cmwt_pkg::ADDR_STATUS, 32'h0, q);
        rr_delay = 0;
        `CHK(q, 32'h3)
        bus(1'b0, cmwt_pkg::ADDR_STATUS, 32'h2, q);
        bus(1'b1, cmwt_pkg::ADDR_STATUS, 32'h0, q);
        `CHK(q, 32'h2)
        bus(1'b0, cmwt_pkg::ADDR_STATUS, 32'h0, q);
        bus(1'b1, cmwt_pkg::ADDR_STATUS, 32'h0, q);
        `CHK({q, irq_a}, 33'h0)
        $display("test flag_clear done");
        // the count wraps through the top of its range
        bus(1'b0, cmwt_pkg::ADDR_COUNT, 32'hFFF0, q);
        bus(1'b1, cmwt_pkg::ADDR_COUNT, 32'h0, q);
        `CHK(q, 32'h0000FFF0)
        bus(1'b0, cmwt_pkg::ADDR_COUNT_START, 32'h1, q);
        repeat (24) @(posedge clk_sys);
        bus(1'b0, cmwt_pkg::ADDR_COUNT_START, 32'h0, q);
        bus(1'b1, cmwt_pkg::ADDR_COUNT, 32'h0, q);
        `CHK(q < 32'h20, 1'b1)
        $display("test wrap done");
        // outside normal mode the pins keep their initial levels
        bus(1'b0, cmwt_pkg::ADDR_TIMER_MODE, 32'h2, q);
        bus(1'b0, cmwt_pkg::ADDR_COUNT_START, 32'h1, q);
        repeat (80) @(posedge clk_sys);
        `CHK({pin_a, pin_b}, 2'b01)
        bus(1'b0, cmwt_pkg::ADDR_COUNT_START, 32'h0, q);
        $display("test mode done");
        // clear on match a, one count per four cycles: 44 run cycles give 11 counts
        bus(1'b0, cmwt_pkg::ADDR_TIMER_CONTROL, 32'h21, q);
        bus(1'b0, cmwt_pkg::ADDR_COUNT, 32'h3C, q);
        bus(1'b0, cmwt_pkg::ADDR_COUNT_START, 32'h1, q);
        repeat (40) @(posedge clk_sys);
        bus(1'b0, cmwt_pkg::ADDR_COUNT_START, 32'h0, q);
        bus(1'b1, cmwt_pkg::ADDR_COUNT, 32'h0, q);
        `CHK(q, 32'h6)
        $display("test prescale_clear done");
        // an unmapped place answers with an error and no data
        bus(1'b1, 8'h2C, 32'h0, q);
        `CHK({resp, q}, {cmwt_pkg::RESP_SLVERR, 32'h0})
        bus(1'b0, 8'h2C, 32'h1, q);
        `CHK(resp, cmwt_pkg::RESP_SLVERR)
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule : cmwt_timer_tb
`default_nettype wire
